/* hdl/sad_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the converter sequencer
// Assumes: AXI4-Lite byte addresses are four times the register index
// Notes: Definitions only
`ifndef SAD_PARAMS_SVH
`define SAD_PARAMS_SVH
`define SAD_IDX_CTRL_A 8'h0e
`define SAD_IDX_CTRL_B 8'h0f
`define SAD_IDX_RES_UP 8'h1f
`define SAD_IDX_STAT_LO 8'h20
`define SAD_IDX_POWER 8'h21
`define SAD_CTRL_A_RST 8'h10
`define SAD_CTRL_B_RST 8'h10
`define SAD_A_START 7
`define SAD_A_MODE_HI 6
`define SAD_A_MODE_LO 5
`define SAD_A_INDIS 4
`define SAD_B_LADDER 5
`define SAD_B_ACK_HI 3
`define SAD_B_ACK_LO 1
`define SAD_S_DONE 5
`define SAD_S_BUSY 4
`define SAD_NUM_CH 4'h6
`define SAD_CYC_000 11'd39
`define SAD_CYC_010 11'd78
`define SAD_CYC_011 11'd156
`define SAD_CYC_100 11'd312
`define SAD_CYC_101 11'd624
`define SAD_CYC_110 11'd1248
`endif

/* hdl/sad_pkg.sv */
// Purpose: Types shared by the converter sequencer
// Assumes: Constants live in sad_params.svh
// Notes: Mode and state enums use written-out codes
package sad_pkg;
  typedef enum logic [1:0] {
    SAD_MODE_OFF = 2'b00,
    SAD_MODE_SINGLE = 2'b01,
    SAD_MODE_RSVD = 2'b10,
    SAD_MODE_REPEAT = 2'b11
  } sad_mode_t;
  typedef enum logic [1:0] {
    SAD_ST_IDLE = 2'b00,
    SAD_ST_CONV = 2'b01
  } sad_state_t;
  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] data;
  } sad_bus_word_t;
endpackage

/* hdl/sad_seq.sv */
// Purpose: Control, status and sequencing of a 10-bit successive-approximation converter
// Assumes: Analog core returns a 10-bit code in sar_code whenever sampled at the end of a run
// Notes: AXI4-Lite slave; power register at index 0x21 reports and drives low-power modes
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "sad_params.svh"

module sad_seq
  import sad_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog core
  input wire logic [9:0] sar_code,
  output logic [2:0] sar_channel,
  output logic sar_sample,
  output logic analog_in_enable,
  output logic ladder_connect,
  // Events
  output logic conv_done_irq
);

  // Register state
  logic [7:0] conversion_control_a;
  logic [7:0] conversion_control_b;
  logic [9:0] result;
  logic conv_done_flag;
  logic conv_busy_flag;
  logic [3:0] noise;
  logic [1:0] power_mode;
  logic standby;
  logic low_power;
  sad_state_t state;
  logic [10:0] count;
  logic [10:0] conv_len;
  sad_mode_t mode;

  // AXI channel state
  logic aw_held;
  logic w_held;
  logic [5:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic rd_go;
  logic [7:0] ar_idx;
  logic [7:0] next_rdata;

  assign mode = sad_mode_t'(conversion_control_a[`SAD_A_MODE_HI:`SAD_A_MODE_LO]);
  // Power field: 00 normal, 01 sleep, 10 slow, 11 stop
  assign low_power = (power_mode != 2'b00);
  assign standby = power_mode[1];

  // Address and data may arrive in either order; each is held until both are in
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign ar_idx = {2'b00, s_axi_araddr[7:2]};
  assign s_axi_bresp = 2'b00;
  assign s_axi_rresp = 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 6'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Write fields, seen combinationally at the completing edge
  logic [7:0] wi;
  logic [7:0] wb;
  logic wb_en;
  assign wi = {2'b00, (aw_held ? aw_idx : s_axi_awaddr[7:2])};
  assign wb = w_held ? w_data[7:0] : s_axi_wdata[7:0];
  assign wb_en = w_held ? w_strb[0] : s_axi_wstrb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_mode <= 2'b00;
    end else if (wr_go && wb_en && wi == `SAD_IDX_POWER) begin
      power_mode <= wb[1:0];
    end
  end

  logic start_now;
  logic finish_now;
  assign finish_now = (state == SAD_ST_CONV) && (count == 11'd1);
  // Reserved mode 10 acts as off, so a run cut by it never stores a result
  logic run_ok;
  assign run_ok = (mode == SAD_MODE_SINGLE || mode == SAD_MODE_REPEAT);
  // Only single and repeat modes may launch
  // Start bit in single mode launches one run
  // Repeat mode relaunches at each completion
  assign start_now = !low_power && (mode == SAD_MODE_SINGLE || mode == SAD_MODE_REPEAT) &&
    ((conversion_control_a[`SAD_A_START] && state == SAD_ST_IDLE) ||
     (finish_now && mode == SAD_MODE_REPEAT));

  // First control register locked in low power
  always_ff @(posedge aclk) begin
    if (!aresetn || low_power) begin
      conversion_control_a <= `SAD_CTRL_A_RST;
    end else begin
      if (wr_go && wb_en && wi == `SAD_IDX_CTRL_A) begin
        conversion_control_a <= wb;
      end else if (start_now) begin
        conversion_control_a[`SAD_A_START] <= 1'b0;
      end
    end
  end

  // Second control register locked in low power
  // Both controls return to reset values
  always_ff @(posedge aclk) begin
    if (!aresetn || low_power) begin
      conversion_control_b <= `SAD_CTRL_B_RST;
    end else if (wr_go && wb_en && wi == `SAD_IDX_CTRL_B) begin
      conversion_control_b <= wb;
    end
  end

  always_comb begin
    case (conversion_control_b[`SAD_B_ACK_HI:`SAD_B_ACK_LO])
      3'b000: conv_len = `SAD_CYC_000;
      3'b010: conv_len = `SAD_CYC_010;
      3'b011: conv_len = `SAD_CYC_011;
      3'b100: conv_len = `SAD_CYC_100;
      3'b101: conv_len = `SAD_CYC_101;
      3'b110: conv_len = `SAD_CYC_110;
      default: conv_len = `SAD_CYC_000;
    endcase
  end

  // Mode 00 or low power halts immediately
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SAD_ST_IDLE;
      count <= 11'd0;
    end else if (low_power || mode == SAD_MODE_OFF || mode == SAD_MODE_RSVD) begin
      state <= SAD_ST_IDLE;
      count <= 11'd0;
    end else begin
      case (state)
        SAD_ST_IDLE: begin
          if (start_now) begin
            state <= SAD_ST_CONV;
            count <= conv_len;
          end
        end
        SAD_ST_CONV: begin
          if (start_now) begin
            count <= conv_len;
          end else if (finish_now) begin
            state <= SAD_ST_IDLE;
          end else begin
            count <= count - 11'd1;
          end
        end
        default: state <= SAD_ST_IDLE;
      endcase
    end
  end

  // Busy follows the run and drops in sleep, slow and stop
  assign conv_busy_flag = (state == SAD_ST_CONV);

  logic rd_upper;
  assign rd_upper = rd_go && ar_idx == `SAD_IDX_RES_UP;

  // Result, done and interrupt on the same edge
  // Standby leaves result indeterminate; cleared here
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      result <= 10'h000;
    end else if (finish_now && !low_power && run_ok) begin
      result <= sar_code;
    end
  end

  // Upper read clears done; completion wins over the clear
  // Fresh start clears done, result kept
  always_ff @(posedge aclk) begin
    if (!aresetn || low_power) begin
      conv_done_flag <= 1'b0;
    end else if (finish_now && run_ok) begin
      conv_done_flag <= 1'b1;
    end else if (rd_upper || (start_now && state == SAD_ST_IDLE)) begin
      conv_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_done_irq <= 1'b0;
    end else begin
      conv_done_irq <= finish_now && !low_power && run_ok;
    end
  end

  // Unstable bits modelled by a free-running LFSR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      noise <= 4'h1;
    end else begin
      noise <= {noise[2:0], noise[3] ^ noise[2]};
    end
  end

  // Reserved channel codes fall back to input 0
  // Channel taken live; software keeps it still while busy
  assign sar_channel = (conversion_control_a[3:0] < `SAD_NUM_CH) ?
    conversion_control_a[2:0] : 3'h0;
  assign sar_sample = start_now;
  // Input-disable bit gates the analog inputs
  assign analog_in_enable = !conversion_control_a[`SAD_A_INDIS];
  assign ladder_connect = conversion_control_b[`SAD_B_LADDER] && !standby;

  // Result split across upper and status
  // Bits 7:6 of second control read unstable
  always_comb begin
    case (ar_idx)
      `SAD_IDX_CTRL_A: next_rdata = conversion_control_a;
      `SAD_IDX_CTRL_B: next_rdata = {noise[1:0], conversion_control_b[5:0]};
      `SAD_IDX_RES_UP: next_rdata = result[9:2];
      `SAD_IDX_STAT_LO: next_rdata = {result[1:0], conv_done_flag, conv_busy_flag, noise};
      `SAD_IDX_POWER: next_rdata = {6'h00, power_mode};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, next_rdata};
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Assertions
  a_start_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    start_now && !(wr_go && wi == `SAD_IDX_CTRL_A) |=> !conversion_control_a[`SAD_A_START])
    else $error("start bit did not clear");
  a_off_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == SAD_MODE_OFF |=> !conv_busy_flag)
    else $error("busy while disabled");
  a_done_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done_irq |-> conv_done_flag && result == $past(sar_code))
    else $error("done, result and interrupt disagree");
  a_repeat_run: assert property (@(posedge aclk) disable iff (!aresetn)
    finish_now && mode == SAD_MODE_REPEAT && !low_power |=> conv_busy_flag)
    else $error("repeat did not restart");
  a_halt_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == SAD_MODE_OFF && !standby |=> $stable(result))
    else $error("result changed while disabled");
  a_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_upper && !finish_now |=> !conv_done_flag)
    else $error("done not cleared by upper read");
  a_low_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    low_power |=> !conv_busy_flag && conversion_control_a == `SAD_CTRL_A_RST)
    else $error("busy or control survived low power");
  a_len_count: assert property (@(posedge aclk) disable iff (!aresetn)
    state == SAD_ST_IDLE && start_now |=> count == $past(conv_len))
    else $error("wrong conversion length");
  a_ladder_off: assert property (@(posedge aclk) disable iff (!aresetn)
    standby |-> !ladder_connect)
    else $error("ladder left connected");
  a_b_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    low_power |=> conversion_control_b == `SAD_CTRL_B_RST)
    else $error("second control written in low power");

endmodule

/* sim/sar_adc_sequencer_tb.sv */
// Purpose: Self-checking bench for the converter sequencer over AXI4-Lite
// Assumes: Register byte address is four times the index; irq is a one-cycle pulse
// Notes: Comb outputs are sampled at the falling edge, where they have settled
`timescale 1ns/1ns
`include "sad_params.svh"
module sar_adc_sequencer_tb;
  import sad_pkg::*;
  localparam logic [7:0] A_CA = 8'(`SAD_IDX_CTRL_A << 2);
  localparam logic [7:0] A_CB = 8'(`SAD_IDX_CTRL_B << 2);
  localparam logic [7:0] A_UP = 8'(`SAD_IDX_RES_UP << 2);
  localparam logic [7:0] A_ST = 8'(`SAD_IDX_STAT_LO << 2);
  localparam logic [7:0] A_PW = 8'(`SAD_IDX_POWER << 2);
  localparam int LO = `SAD_CYC_000 - 4;
  localparam int HI = `SAD_CYC_000 + 8;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [9:0] sar_code = 10'h2b5;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd;
  logic [2:0] sar_channel;
  logic sar_sample, analog_in_enable, ladder_connect, conv_done_irq;
  int err_count = 0, checks = 0, cyc = 0, n;
  int starts = 0;
  logic [1:0] br, rr;
  sad_seq uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sar_code(sar_code), .sar_channel(sar_channel),
    .sar_sample(sar_sample), .analog_in_enable(analog_in_enable),
    .ladder_connect(ladder_connect), .conv_done_irq(conv_done_irq));
  always #25 aclk = ~aclk;
  // Count launch pulses; each run must show exactly one
  always @(negedge aclk) if (sar_sample === 1'b1) starts <= starts + 1;
  // Whole run needs a few hundred cycles; the ceiling leaves ample slack
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      final_report();
    end
  end
  task automatic final_report();
    $display("err_count=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, da, dw;
    da = 0;
    dw = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ha = !da && s_axi_awready;
      hw = !dw && s_axi_wready;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      da = da | ha;
      dw = dw | hw;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  // Cycles until the next completion pulse, or lim when none comes
  task automatic wirq(input int lim, output int c);
    c = 0;
    do begin
      @(negedge aclk);
      c = c + 1;
    end while (conv_done_irq !== 1'b1 && c < lim);
  endtask
  task automatic t_reset_vals();
    axr(A_CA, rd);
    chk("ctrl_a rst", rd, 32'h10);
    chk("in enable", analog_in_enable, 1'b0);
    axr(A_CB, rd);
    chk("ctrl_b rst", rd & 32'h3f, 32'h10);
    axw(8'h90, 32'hff);
    axr(8'h90, rd);
    chk("unmapped", rd, 32'h0);
    chk("bresp", br, 2'b00);
    chk("rresp", rr, 2'b00);
    axw(A_CA, 32'hc0);
    wirq(100, n);
    chk("rsvd mode", n, 100);
    chk("no launch", starts, 0);
  endtask
  task automatic t_single();
    // Bit 0 low, bit 4 high
    axw(A_CB, 32'h30);
    axw(A_CA, 32'ha3);
    @(negedge aclk);
    chk("channel", sar_channel, 3'd3);
    chk("in enable", analog_in_enable, 1'b1);
    chk("ladder", ladder_connect, 1'b1);
    wirq(2000, n);
    chk("single time", n >= LO && n <= HI, 1'b1);
    axr(A_CA, rd);
    chk("start clr", rd, 32'h23);
    axr(A_ST, rd);
    chk("status", rd & 32'hf0, 32'h60);
    chk("single launch", starts, 1);
  endtask
  task automatic t_repeat_abort();
    sar_code <= 10'h1ca;
    // Fresh start clears done and keeps the old result
    axw(A_CA, 32'he5);
    axr(A_ST, rd);
    chk("restart flags", rd & 32'h30, 32'h10);
    axr(A_UP, rd);
    chk("old result", rd, 32'had);
    wirq(2000, n);
    wirq(2000, n);
    chk("repeat time", n >= LO && n <= HI, 1'b1);
    axr(A_ST, rd);
    chk("done set", rd & 32'he0, 32'ha0);
    axr(A_UP, rd);
    chk("new result", rd, 32'h72);
    axr(A_ST, rd);
    chk("done clr", rd & 32'h20, 32'h0);
    sar_code <= 10'h3ff;
    axw(A_CA, 32'h05);
    wirq(100, n);
    chk("halted", n, 100);
    axr(A_ST, rd);
    chk("busy off", rd & 32'h30, 32'h0);
    axr(A_UP, rd);
    chk("kept result", rd, 32'h72);
    chk("repeat launches", starts, 4);
  endtask
  task automatic t_lowpower();
    axw(A_CA, 32'ha0);
    axw(A_PW, 32'h3);
    @(negedge aclk);
    chk("ladder off", ladder_connect, 1'b0);
    axr(A_CA, rd);
    chk("ctrl_a init", rd, 32'h10);
    axr(A_CB, rd);
    chk("ctrl_b init", rd & 32'h3f, 32'h10);
    axr(A_ST, rd);
    chk("stop busy", rd & 32'h30, 32'h0);
    axr(A_UP, rd);
    chk("result gone", rd, 32'h0);
    axw(A_CA, 32'ha3);
    axw(A_CB, 32'h3e);
    axr(A_CA, rd);
    chk("ctrl_a lock", rd, 32'h10);
    axr(A_CB, rd);
    chk("ctrl_b lock", rd & 32'h3f, 32'h10);
    axw(A_PW, 32'h0);
    wirq(100, n);
    chk("no restart", n, 100);
    chk("total launches", starts, 5);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_vals();
    t_single();
    t_repeat_abort();
    t_lowpower();
    final_report();
  end
endmodule
